/* File: rtl/fsp_core.v */
// Notes on behaviour
// [RQ1] outside block receive, data register read returns last received byte in bits 7:0
// [RQ2] data register write sends exactly one byte from bits 7:0
// [RQ3] software checks transmit-ready before writing the data register
// [RQ4] software writes zeros to reserved bits of data and counter registers
// [RQ5] receive base pointer is 16-bit, read/write, resets to zero
// [RQ6] loading receive counter with length minus one starts block receive
// [RQ7] receive counter decrements per received byte and reads remaining length
// [RQ8] finished block counter reads 0x03FF until reloaded
// [RQ9] counters are ten bits, max 1023; one count is one byte here
// [RQ10] transmit base pointer is 16-bit, read/write, resets to zero
// [RQ11] loading transmit counter with length minus one starts block transmit
// [RQ12] transmit counter decrements per sent byte and reads remaining length
// [RQ13] receive-ready bit 0 is one while receive fifo holds a byte
// [RQ14] transmit-ready bit 4 is one when transmitter can take a byte
// [RQ15] transmit-done bit 7 sets on block transmit end, cleared by writing one
// [RQ16] all transfers proceed only while enable bit 15 is one
// [RQ17] block transmit fetches ascending addresses from transmit base
// [RQ18] block receive stores ascending addresses from receive base
`timescale 1ns/1ps
`include "fsp_defs.vh"
module fsp_core #(
   parameter FIFO_AW = 3
) (
   // clock and reset
   input  wire        clock,
   input  wire        resetn,
   input  wire        ce,
   // register port
   input  wire [15:0] reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // memory master for block transfers
   output reg  [15:0] mem_addr,
   output reg  [7:0]  mem_wdata,
   output reg         mem_wr,
   output reg         mem_rd,
   input  wire [7:0]  mem_rdata,
   // serial line
   input  wire        ser_rx,
   output reg         ser_tx,
   // interrupt
   output wire        irq
);
   ////////////////////////////////////////////////////////////////////////////
   localparam TX_IDLE  = 2'h0;
   localparam TX_FETCH = 2'h1;
   localparam TX_WAIT  = 2'h2;
   localparam TX_SHIFT = 2'h3;

   function hit;
      input [15:0] a;
      input [15:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   wire wr_ctrl = reg_wr && hit(reg_addr, `FSP_OFF_CTRL);
   wire wr_data = reg_wr && hit(reg_addr, `FSP_OFF_DATA);
   wire wr_rxc  = reg_wr && hit(reg_addr, `FSP_OFF_RXCNT);
   wire wr_txc  = reg_wr && hit(reg_addr, `FSP_OFF_TXCNT);
   wire rd_data = reg_rd && hit(reg_addr, `FSP_OFF_DATA);

   reg         en_r;
   reg         onestop_r;
   reg  [12:0] baud_r;
   reg  [7:0]  gap_r;
   reg  [15:0] rxbase_r;
   reg  [15:0] txbase_r;
   reg  [9:0]  rxcnt_r;
   reg  [9:0]  txcnt_r;
   reg         rxblk_r;
   reg         txblk_r;
   reg  [15:0] rxptr_r;
   reg  [15:0] txptr_r;
   reg  [3:0]  stat_r;
   reg  [3:0]  mask_r;
   reg  [7:0]  last_rx_r;
   reg  [15:0] rdata_r;
   reg         data_pend_r;

   ////////////////////////////////////////////////////////////////////////////
   // receiver: start bit, 8 data, one stop, sampled at mid-bit
   reg  [12:0] rx_div_r;
   reg  [3:0]  rx_bit_r;
   reg  [8:0]  rx_sh_r;
   reg         rx_busy_r;
   reg         rx_done;
   wire [FIFO_AW:0] rx_count;
   wire [7:0]       fifo_q;
   wire        rx_to_fifo = rx_done && !rxblk_r;
   // a block receive store owns the memory bus in the cycle after a byte lands
   wire        rx_store   = rx_done && rxblk_r && en_r && !wr_rxc;
   wire        fifo_full  = (rx_count == (1 << FIFO_AW));

   fsp_rxfifo #(.W(8), .AW(FIFO_AW)) u_rxfifo (
      .clock   (clock),
      .resetn  (resetn),
      .ce      (ce),
      .wr_en   (rx_to_fifo),
      .wr_data (rx_sh_r[7:0]),
      .rd_en   (rd_data && !rxblk_r),
      .rd_data (fifo_q),
      .count_r (rx_count)
   );

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_div_r  <= 13'h0000;
         rx_bit_r  <= 4'h0;
         rx_sh_r   <= 9'h000;
         rx_busy_r <= 1'b0;
         rx_done   <= 1'b0;
      end else if (ce) begin
         rx_done <= 1'b0;
         if (!en_r) begin // RQ16
            rx_busy_r <= 1'b0;
         end else if (!rx_busy_r) begin
            if (!ser_rx) begin
               rx_busy_r <= 1'b1;
               rx_bit_r  <= 4'h0;
               rx_div_r  <= {1'b0, baud_r[12:1]};
            end
         end else if (rx_div_r != 13'h0000) begin
            rx_div_r <= rx_div_r - 13'h0001;
         end else begin
            rx_div_r <= baud_r;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0) begin
               if (ser_rx)
                  rx_busy_r <= 1'b0;
            end else begin
               rx_sh_r <= {ser_rx, rx_sh_r[8:1]};
               if (rx_bit_r == 4'h9) begin
                  rx_busy_r <= 1'b0;
                  rx_done   <= 1'b1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmitter, single byte or block
   reg  [1:0]  tx_st_r;
   reg  [12:0] tx_div_r;
   reg  [4:0]  tx_left_r;
   reg  [8:0]  tx_sh_r;
   reg  [7:0]  tx_gap_r;
   wire        tx_ready = (tx_st_r == TX_IDLE) && !txblk_r;
   wire        tx_end   = (tx_st_r == TX_SHIFT) && (tx_div_r == 13'h0000)
                          && (tx_left_r == 5'h00) && (tx_gap_r == 8'h00);
   wire        txblk_fin = txblk_r && tx_end && (txcnt_r == `FSP_CNT_DONE);
   // stop time in bit times after the first stop bit: 1 or 2 by onestop, or gap - 7 in block mode
   wire [7:0]  stop_bits = txblk_r ? (gap_r - `FSP_GAP_BASE) :
                           (onestop_r ? 8'h01 : 8'h02);

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_st_r   <= TX_IDLE;
         tx_div_r  <= 13'h0000;
         tx_left_r <= 5'h00;
         tx_sh_r   <= 9'h1FF;
         tx_gap_r  <= 8'h00;
         ser_tx    <= 1'b1;
         mem_rd    <= 1'b0;
         mem_addr  <= 16'h0000;
         txptr_r   <= 16'h0000;
      end else if (ce) begin
         mem_rd <= 1'b0;
         if (rx_store)
            mem_addr <= rxptr_r; // RQ18
         if (!en_r) begin // RQ16
            tx_st_r <= TX_IDLE;
            ser_tx  <= 1'b1;
         end else begin
            case (tx_st_r)
               TX_IDLE: begin
                  if (wr_txc) begin
                     txptr_r <= txbase_r; // RQ17
                     tx_st_r <= TX_FETCH;
                  end else if (wr_data && !txblk_r) begin // RQ2
                     tx_sh_r   <= {reg_wdata[7:0], 1'b0};
                     tx_left_r <= 5'h09;
                     tx_div_r  <= baud_r;
                     tx_gap_r  <= stop_bits;
                     tx_st_r   <= TX_SHIFT;
                  end
               end
               TX_FETCH: begin
                  // fetch waits while a receive store holds the bus
                  if (!rx_store) begin
                     mem_addr <= txptr_r;
                     mem_rd   <= 1'b1;
                     txptr_r  <= txptr_r + 16'h0001; // RQ17
                     tx_st_r  <= TX_WAIT;
                  end
               end
               TX_WAIT: begin
                  // registered memory: data stand in the cycle after the strobe
                  if (!mem_rd) begin
                     tx_sh_r   <= {mem_rdata, 1'b0};
                     tx_left_r <= 5'h09;
                     tx_div_r  <= baud_r;
                     tx_gap_r  <= stop_bits;
                     tx_st_r   <= TX_SHIFT;
                  end
               end
               TX_SHIFT: begin
                  if (tx_left_r != 5'h00)
                     ser_tx <= tx_sh_r[0];
                  else
                     ser_tx <= 1'b1;
                  if (tx_div_r != 13'h0000) begin
                     tx_div_r <= tx_div_r - 13'h0001;
                  end else begin
                     tx_div_r <= baud_r;
                     if (tx_left_r != 5'h00) begin
                        tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
                        tx_left_r <= tx_left_r - 5'h01;
                     end else if (tx_gap_r != 8'h00) begin
                        tx_gap_r <= tx_gap_r - 8'h01;
                     end else if (txblk_r && txcnt_r != `FSP_CNT_DONE) begin
                        tx_st_r <= TX_FETCH;
                     end else begin
                        tx_st_r <= TX_IDLE;
                     end
                  end
               end
               default: tx_st_r <= TX_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // block counters, pointers and status
   wire rxblk_byte = rxblk_r && rx_done;
   wire ev_txdone  = txblk_fin;
   wire ev_rxdone  = rxblk_byte && (rxcnt_r == 10'h000);
   wire ev_ovf     = rx_to_fifo && fifo_full;
   wire [3:0] ev   = {ev_txdone, ev_rxdone, ev_ovf, 1'b0};
   wire [3:0] clr  = wr_ctrl ? {reg_wdata[`FSP_CTRL_TXDONE],
                                reg_wdata[`FSP_CTRL_RXDONE],
                                reg_wdata[`FSP_CTRL_OVF], 1'b0} : 4'h0;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         en_r      <= 1'b0;
         onestop_r <= 1'b0;
         baud_r    <= `FSP_BAUD_RST;
         gap_r     <= `FSP_GAP_RST;
         rxbase_r  <= 16'h0000;
         txbase_r  <= 16'h0000;
         rxcnt_r   <= 10'h000;
         txcnt_r   <= 10'h000;
         rxblk_r   <= 1'b0;
         txblk_r   <= 1'b0;
         rxptr_r   <= 16'h0000;
         stat_r    <= 4'h0;
         mask_r    <= 4'h0;
         mem_wr    <= 1'b0;
         mem_wdata <= 8'h00;
         last_rx_r <= 8'h00;
      end else if (ce) begin
         mem_wr <= 1'b0;
         // set beats clear in the same cycle
         stat_r <= (stat_r & ~clr) | ev; // RQ15
         if (wr_ctrl) begin
            en_r      <= reg_wdata[`FSP_CTRL_EN];
            onestop_r <= reg_wdata[`FSP_CTRL_ONESTOP];
         end
         if (reg_wr && hit(reg_addr, `FSP_OFF_BAUD))
            baud_r <= reg_wdata[12:0];
         if (reg_wr && hit(reg_addr, `FSP_OFF_GAP))
            gap_r <= reg_wdata[7:0];
         if (reg_wr && hit(reg_addr, `FSP_OFF_IMASK))
            mask_r <= reg_wdata[3:0];
         if (reg_wr && hit(reg_addr, `FSP_OFF_RXBASE))
            rxbase_r <= reg_wdata; // RQ5
         if (reg_wr && hit(reg_addr, `FSP_OFF_TXBASE))
            txbase_r <= reg_wdata; // RQ10
         if (data_pend_r)
            last_rx_r <= fifo_q;
         // receive block
         if (wr_rxc && en_r) begin
            rxcnt_r <= reg_wdata[9:0]; // RQ6 RQ9
            rxblk_r <= 1'b1;
            rxptr_r <= rxbase_r;
         end else if (rx_store) begin
            mem_wdata <= rx_sh_r[7:0];
            mem_wr    <= 1'b1;
            rxptr_r   <= rxptr_r + 16'h0001; // RQ18
            rxcnt_r   <= rxcnt_r - 10'h001; // RQ7 RQ8
            if (rxcnt_r == 10'h000)
               rxblk_r <= 1'b0;
         end
         // transmit block: counter drops as each byte is fetched from memory
         if (wr_txc && en_r && tx_st_r == TX_IDLE) begin
            txcnt_r <= reg_wdata[9:0]; // RQ11 RQ9
            txblk_r <= 1'b1;
         end else if (txblk_r && tx_st_r == TX_FETCH && !rx_store) begin
            txcnt_r <= txcnt_r - 10'h001; // RQ12 RQ8
         end else if (txblk_fin || !en_r) begin
            txblk_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read, one cycle later
   assign irq = |(stat_r & mask_r);

   // fifo head comes out of its own register in the answer cycle, so it is muxed in
   always @* begin
      reg_rdata = rdata_r;
      if (data_pend_r)
         reg_rdata = {8'h00, fifo_q}; // RQ1
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdata_r     <= 16'h0000;
         data_pend_r <= 1'b0;
      end else if (ce) begin
         rdata_r     <= 16'h0000;
         data_pend_r <= rd_data && !rxblk_r;
         if (reg_rd) begin
            case (reg_addr)
               `FSP_OFF_CTRL:   rdata_r <= {en_r, 7'h00, stat_r[3], stat_r[2], onestop_r,
                                            tx_ready, 1'b0, stat_r[1],
                                            (rx_count >= `FSP_RXFIFO_FULL),
                                            (rx_count != 0)}; // RQ13 RQ14
               `FSP_OFF_BAUD:   rdata_r <= {3'h0, baud_r};
               `FSP_OFF_GAP:    rdata_r <= {8'h00, gap_r};
               `FSP_OFF_DATA:   rdata_r <= {8'h00, last_rx_r}; // RQ1
               `FSP_OFF_RXBASE: rdata_r <= rxbase_r;
               `FSP_OFF_RXCNT:  rdata_r <= {6'h00, rxcnt_r}; // RQ7
               `FSP_OFF_TXBASE: rdata_r <= txbase_r;
               `FSP_OFF_TXCNT:  rdata_r <= {6'h00, txcnt_r}; // RQ12
               `FSP_OFF_IMASK:  rdata_r <= {12'h000, mask_r};
               default:         rdata_r <= 16'h0000;
            endcase
         end
      end
   end
endmodule

/* File: rtl/fsp_defs.vh */
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// register byte addresses (16-bit cpu register space)
`define FSP_OFF_CTRL     16'hC070
`define FSP_OFF_BAUD     16'hC072
`define FSP_OFF_GAP      16'hC074
`define FSP_OFF_DATA     16'hC076
`define FSP_OFF_RXBASE   16'hC078
`define FSP_OFF_RXCNT    16'hC07A
`define FSP_OFF_TXBASE   16'hC07C
`define FSP_OFF_TXCNT    16'hC07E
`define FSP_OFF_IMASK    16'hC080

// control register bit positions
`define FSP_CTRL_EN      15
`define FSP_CTRL_TXDONE  7
`define FSP_CTRL_RXDONE  6
`define FSP_CTRL_ONESTOP 5
`define FSP_CTRL_TXRDY   4
`define FSP_CTRL_OVF     2
`define FSP_CTRL_RXPKT   1
`define FSP_CTRL_RXRDY   0

// reset values, finished counter value and counter width
`define FSP_BAUD_RST     13'h0017
`define FSP_GAP_RST      8'h09
`define FSP_CNT_DONE     10'h3FF
`define FSP_CNT_W        10

// timing: gap value that equals one stop bit
`define FSP_GAP_BASE     8'h07
`define FSP_RXFIFO_FULL  4'h8

`endif

/* File: rtl/fsp_rxfifo.v */
`timescale 1ns/1ps
module fsp_rxfifo #(
   parameter W  = 8,
   parameter AW = 3
) (
   // clock
   input  wire          clock,
   input  wire          resetn,
   input  wire          ce,
   // write side
   input  wire          wr_en,
   input  wire [W-1:0]  wr_data,
   // read side
   input  wire          rd_en,
   output reg  [W-1:0]  rd_data,
   output reg  [AW:0]   count_r
);
   reg [W-1:0]  mem [0:(1<<AW)-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   wire         do_wr = wr_en && (count_r != (1 << AW));
   wire         do_rd = rd_en && (count_r != {(AW+1){1'b0}});

   // memory itself has no reset so it can map onto ram
   always @(posedge clock) begin
      if (ce && do_wr)
         mem[wp_r] <= wr_data;
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wp_r    <= {AW{1'b0}};
         rp_r    <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
         rd_data <= {W{1'b0}};
      end else if (ce) begin
         if (do_wr)
            wp_r <= wp_r + 1'b1;
         if (do_rd) begin
            rp_r <= rp_r + 1'b1;
            rd_data <= mem[rp_r];
         end
         if (do_wr && !do_rd)
            count_r <= count_r + 1'b1;
         else if (do_rd && !do_wr)
            count_r <= count_r - 1'b1;
      end
   end
endmodule

/* File: verification/fsp_core_asserts.sv */
`timescale 1ns/1ps
`include "fsp_defs.vh"
module fsp_core_asserts (
   // clock and reset
   input wire        clock,
   input wire        resetn,
   input wire        ce,
   // register port
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   // memory master
   input wire [15:0] mem_addr,
   input wire [7:0]  mem_wdata,
   input wire        mem_wr,
   input wire        mem_rd,
   input wire [7:0]  mem_rdata,
   // serial line and interrupt
   input wire        ser_rx,
   input wire        ser_tx,
   input wire        irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   // shadow of the enable bit, so the port can be judged without seeing inside
   reg en_seen_r;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         en_seen_r <= 1'b0;
      end else if (ce && reg_wr && reg_addr == `FSP_OFF_CTRL) begin
         en_seen_r <= reg_wdata[`FSP_CTRL_EN];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read answer cycle");
   unmapped_zero_a: assert property ($past(reg_rd) && ($past(reg_addr) < 16'hC070
      || $past(reg_addr) > 16'hC080) |-> reg_rdata == 16'h0000)
      else $error("unmapped read returned nonzero");
   cnt_width_a: assert property ($past(reg_rd) && ($past(reg_addr) == 16'hC07A
      || $past(reg_addr) == 16'hC07E) |-> reg_rdata[15:10] == 6'h00)
      else $error("counter read has bits above nine set");
   // the line returns to idle one cycle after the enable bit drops
   off_quiet_a: assert property (!en_seen_r && !$past(en_seen_r) |-> ser_tx && !mem_rd && !mem_wr)
      else $error("activity while port disabled");
   start_bit_a: assert property ($fell(ser_tx) |-> !ser_tx [*8])
      else $error("start bit too short");
   fetch_pulse_a: assert property (mem_rd |=> !mem_rd)
      else $error("fetch strobe longer than one cycle");
   store_pulse_a: assert property (mem_wr |=> !mem_wr)
      else $error("store strobe longer than one cycle");
   mem_excl_a: assert property (not (mem_rd && mem_wr))
      else $error("fetch and store at once");
endmodule

/* File: verification/fsp_peer.sv */
`timescale 1ns/1ps
module fsp_peer #(
   parameter BIT = 24
) (
   // clock
   input wire        clock,
   // memory side
   input wire [15:0] mem_addr,
   input wire [7:0]  mem_wdata,
   input wire        mem_wr,
   input wire        mem_rd,
   output reg [7:0]  mem_rdata,
   // serial side
   input wire        ser_tx,
   output reg        ser_rx
);
   logic [7:0] mem [0:1023];
   logic [7:0] got [$];
   logic [7:0] b;
   initial begin
      mem_rdata = 8'h00;
      ser_rx = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // outside the answer cycle the data toggles, so a late sample is never lucky
   always @(posedge clock) begin
      if (mem_wr) begin
         mem[mem_addr[9:0]] <= mem_wdata;
      end
      mem_rdata <= mem_rd ? mem[mem_addr[9:0]] : ~mem_rdata;
   end
   // sample mid-bit, lsb first
   initial begin
      forever begin
         @(negedge ser_tx);
         repeat (BIT + BIT / 2) @(posedge clock);
         for (int i = 0; i < 8; i++) begin
            b[i] = ser_tx;
            repeat (BIT) @(posedge clock);
         end
         got.push_back(b);
      end
   end
   task send_byte(input logic [7:0] d);
      begin
         @(posedge clock);
         ser_rx <= 1'b0;
         repeat (BIT) @(posedge clock);
         for (int i = 0; i < 8; i++) begin
            ser_rx <= d[i];
            repeat (BIT) @(posedge clock);
         end
         ser_rx <= 1'b1;
         repeat (2 * BIT) @(posedge clock);
      end
   endtask
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`include "fsp_defs.vh"
module testbench;
   logic        clock;
   logic        resetn;
   logic        ce;
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic [15:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic        mem_wr;
   logic        mem_rd;
   wire  [7:0]  mem_rdata;
   wire         ser_rx;
   logic        ser_tx;
   logic        irq;
   logic [15:0] r;
   int          n_mismatch = 0;
   int          n_compared = 0;
   fsp_core #(.FIFO_AW(3)) i_fsp_core (.clock(clock), .resetn(resetn), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
      .mem_rd(mem_rd), .mem_rdata(mem_rdata), .ser_rx(ser_rx), .ser_tx(ser_tx), .irq(irq));
   fsp_peer #(.BIT(24)) i_fsp_peer (.clock(clock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .ser_tx(ser_tx), .ser_rx(ser_rx));
   ////////////////////////////////////////////////////////////////////////////////
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [15:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
   endtask
   task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bounded poll of one control bit
   task poll(input int b, input logic v);
      for (int k = 0; k < 1000; k++) begin
         rd(`FSP_OFF_CTRL);
         if (r[b] === v) break;
      end
   endtask
   task wait_got(input int n);
      for (int k = 0; k < 3000 && i_fsp_peer.got.size() < n; k++) @(posedge clock);
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_regs;
      for (int i = 0; i < 4; i++) begin
         rd(16'hC078 + 16'(2 * i));
         chk("reset value", r, 16'h0000);
      end
      wr(`FSP_OFF_RXBASE, 16'h1234);
      wr(`FSP_OFF_TXBASE, 16'hABCD);
      rd(`FSP_OFF_RXBASE);
      chk("rx base", r, 16'h1234);
      rd(`FSP_OFF_TXBASE);
      chk("tx base", r, 16'hABCD);
      rd(16'hC090);
      chk("unmapped", r, 16'h0000);
      $display("test regs done");
   endtask
   task t_single_tx;
      wr(`FSP_OFF_CTRL, 16'h8020);
      poll(`FSP_CTRL_TXRDY, 1'b1);
      chk("tx ready", {15'h0, r[4]}, 16'h0001);
      wr(`FSP_OFF_DATA, 16'h00A5);
      wait_got(1);
      chk("tx byte", {8'h00, i_fsp_peer.got.pop_front()}, 16'h00A5);
      $display("test single tx done");
   endtask
   task t_single_rx;
      i_fsp_peer.send_byte(8'h3C);
      poll(`FSP_CTRL_RXRDY, 1'b1);
      chk("rx ready", {15'h0, r[0]}, 16'h0001);
      rd(`FSP_OFF_DATA);
      chk("rx byte", {8'h00, r[7:0]}, 16'h003C);
      rd(`FSP_OFF_CTRL);
      chk("rx empty", {15'h0, r[0]}, 16'h0000);
      $display("test single rx done");
   endtask
   task t_block_tx;
      for (int i = 0; i < 3; i++) i_fsp_peer.mem[256 + i] = 8'(8'h11 * (i + 1));
      wr(`FSP_OFF_TXBASE, 16'h0100);
      wr(`FSP_OFF_IMASK, 16'h0008);
      wr(`FSP_OFF_TXCNT, 16'h0002);
      wait_got(3);
      for (int i = 0; i < 3; i++) begin
         chk("block tx byte", {8'h00, i_fsp_peer.got.pop_front()}, 16'(8'h11 * (i + 1)));
      end
      poll(`FSP_CTRL_TXDONE, 1'b1);
      chk("tx done", {15'h0, r[7]}, 16'h0001);
      chk("irq set", {15'h0, irq}, 16'h0001);
      rd(`FSP_OFF_TXCNT);
      chk("tx count end", r, 16'h03FF);
      wr(`FSP_OFF_CTRL, 16'h8080);
      rd(`FSP_OFF_CTRL);
      chk("tx done clear", {15'h0, r[7]}, 16'h0000);
      chk("irq clear", {15'h0, irq}, 16'h0000);
      $display("test block tx done");
   endtask
   task t_block_rx;
      wr(`FSP_OFF_RXBASE, 16'h0200);
      wr(`FSP_OFF_RXCNT, 16'h0001);
      i_fsp_peer.send_byte(8'hA1);
      rd(`FSP_OFF_RXCNT);
      chk("rx count mid", r, 16'h0000);
      i_fsp_peer.send_byte(8'hB2);
      rd(`FSP_OFF_RXCNT);
      chk("rx count end", r, 16'h03FF);
      chk("store 0", {8'h00, i_fsp_peer.mem[512]}, 16'h00A1);
      chk("store 1", {8'h00, i_fsp_peer.mem[513]}, 16'h00B2);
      $display("test block rx done");
   endtask
   task t_disable;
      wr(`FSP_OFF_CTRL, 16'h0000);
      wr(`FSP_OFF_DATA, 16'h005A);
      repeat (400) @(posedge clock);
      chk("no tx when off", 16'(i_fsp_peer.got.size()), 16'h0000);
      $display("test disable done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      t_regs;
      t_single_tx;
      t_single_rx;
      t_block_tx;
      t_block_rx;
      t_disable;
      wrap_up;
   end
   // all tests need well under 20000 cycles
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      wrap_up;
   end
endmodule
bind fsp_core fsp_core_asserts i_fsp_core_asserts (.clock(clock), .resetn(resetn), .ce(ce),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
   .mem_rd(mem_rd), .mem_rdata(mem_rdata), .ser_rx(ser_rx), .ser_tx(ser_tx), .irq(irq));
